// ### paru_defs.vh
/*
 Constants of the paged address relocation unit: register offsets,
 field positions, reset values and mode and access key codes.
 Assumes inclusion by bare name from the design files of the unit that use its constants.
*/
// Function
// - When enabled, 16-bit virtual addresses become 18-bit or 22-bit physical addresses.
// - Memory is handled in 64-byte blocks; pages span 1 to 128 blocks.
// - Each mapping set holds eight entries covering the whole 64 KB space.
// - A page may start at any 64-byte aligned physical address.
// - Accesses beyond the allocated length of a short page are refused.
// - Each page uses its own entry; entries may share physical regions.
// - Each page has an access key: read/write, read-only or nonresident.
// - Kernel, supervisor and user modes exist; kernel runs every instruction.
// - Supervisor has user privileges but its own mapping set.
// - Privileged instructions such as halt and reset are refused outside kernel.
// - Unit registers live in the I/O page; only kernel may change them.
// - With relocation on, vector fetches are kernel data references.
// - The two-word vector is relocated through the kernel page base registers.
// - Old counter and status go to the stack chosen by new status bits 15:14.
// - After a vectored transfer the new mode bits choose the mapping set.
// - Virtual address bits 15:13 pick one of eight entries of the set.
// - Each page base register holds the page start as a block number.
// - The access field decides complete, complete-then-trap, or abort; traps wait.
`ifndef PARU_DEFS_VH
`define PARU_DEFS_VH

`define PARU_OFF_CTRL   12'h100
`define PARU_OFF_STAT   12'h104
`define PARU_OFF_FADR   12'h108
`define PARU_MAP_SEL    8
`define PARU_MAP_DESC   7

`define PARU_CTRL_EN    0
`define PARU_CTRL_W22   1
`define PARU_CTRL_RST   2'h0
`define PARU_STAT_ABT   0
`define PARU_STAT_TRP   1

`define PARU_DESC_LEN_HI 14
`define PARU_DESC_LEN_LO 8

`define PARU_MODE_KER   2'h0
`define PARU_MODE_SUP   2'h1
`define PARU_MODE_USR   2'h3
`define PARU_MODE_HI    15
`define PARU_MODE_LO    14

`define PARU_BLK_BITS   6
`define PARU_KEY_RO_TRP 3'h1
`define PARU_KEY_RO     3'h2
`define PARU_KEY_RW_TRP 3'h4
`define PARU_KEY_RW     3'h5

`endif

// ### paru_map_mem.v
/*
 Mapping entry store: one field per entry, byte-enabled write port and
 two read ports whose data come out of registers one cycle later.
 Assumes a single clock shared with the unit.
*/
`timescale 1ns/1ps
`default_nettype none
module paru_map_mem #(
    parameter WIDTH = 16,
    parameter AW    = 5
) (
    input  wire             clk_i,   // Clock
    input  wire             we_i,    // Write strobe
    input  wire [1:0]       be_i,    // Byte enables
    input  wire [AW-1:0]    wa_i,    // Write index
    input  wire [WIDTH-1:0] wd_i,    // Write data
    input  wire [AW-1:0]    ra_i,    // Translate read index
    output reg  [WIDTH-1:0] rd_o,    // Translate read data
    input  wire [AW-1:0]    rb_i,    // Bus read index
    output reg  [WIDTH-1:0] rbd_o    // Bus read data
);
    reg [WIDTH-1:0] mem_q [0:(1<<AW)-1];
    integer i;

    always @(posedge clk_i) begin
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (we_i && be_i[i/8])
                mem_q[wa_i][i] <= wd_i[i];
        end
        rd_o  <= mem_q[ra_i];
        rbd_o <= mem_q[rb_i];
    end
endmodule // paru_map_mem
`default_nettype wire

// ### paru_mode_ctl.v
/*
 Execution mode tracking: current mode, stack choice on vectored
 transfers and the privileged instruction check.
 Assumes the core presents status loads and vector words as pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "paru_defs.vh"
module paru_mode_ctl #(
    parameter SUP_EN = 1
) (
    input  wire        clk_i,         // Clock
    input  wire        rst_i,         // Sync reset
    input  wire        stat_load_i,     // Status word load
    input  wire [15:0] stat_i,          // Loaded status word
    input  wire        vec_stat_valid_i,// Vector status strobe
    input  wire [15:0] vec_stat_i,      // Status word from vector
    input  wire        priv_instr_i,  // Privileged instruction
    output reg  [1:0]  cur_mode_o,    // Current mode
    output reg  [1:0]  stack_mode_o,  // Push stack mode
    output reg         stack_push_o,  // Push pulse
    output reg         priv_fault_o,  // Refused instruction
    output wire        mode_ok_o      // Mode has a set
);
    wire [1:0] vec_mode = vec_stat_i[`PARU_MODE_HI:`PARU_MODE_LO];

    assign mode_ok_o = (cur_mode_o == `PARU_MODE_KER) ||
                       (cur_mode_o == `PARU_MODE_USR) ||
                       (SUP_EN != 0 && cur_mode_o == `PARU_MODE_SUP);

    always @(posedge clk_i) begin
        if (rst_i) begin
            cur_mode_o   <= `PARU_MODE_KER;
            stack_mode_o <= `PARU_MODE_KER;
            stack_push_o <= 1'b0;
            priv_fault_o <= 1'b0;
        end else begin
            stack_push_o <= vec_stat_valid_i;
            priv_fault_o <= priv_instr_i && (cur_mode_o != `PARU_MODE_KER);
            if (vec_stat_valid_i) begin
                stack_mode_o <= vec_mode;
                cur_mode_o   <= vec_mode;
            end else if (stat_load_i) begin
                cur_mode_o <= stat_i[`PARU_MODE_HI:`PARU_MODE_LO];
            end
        end
    end
endmodule // paru_mode_ctl
`default_nettype wire

// ### paru_top.v
/*
 Paged address relocation unit: Wishbone register slave, mapping
 store, two-stage translation pipeline, access checks and trap hold.
 Assumes the core shares clk_i and issues at most one reference a cycle.
*/
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "paru_defs.vh"
module paru_top #(
    parameter SUP_EN = 1,
    parameter PAGES  = 8
) (
    input  wire        clk_i,          // Clock
    input  wire        rst_i,          // Sync reset
    input  wire        wb_cyc_i,       // Bus cycle
    input  wire        wb_stb_i,       // Bus strobe
    input  wire        wb_we_i,        // Bus write
    input  wire [11:0] wb_adr_i,       // Byte address
    input  wire [3:0]  wb_sel_i,       // Byte enables
    input  wire [31:0] wb_dat_i,       // Write data
    output reg  [31:0] wb_dat_o,       // Read data
    output reg         wb_ack_o,       // Acknowledge
    input  wire        req_valid_i,    // Reference valid
    input  wire [15:0] req_vaddr_i,    // Virtual address
    input  wire        req_write_i,    // Write reference
    input  wire        req_vector_i,   // Vector fetch
    output reg         resp_valid_o,   // Result pulse
    output reg  [21:0] resp_paddr_o,   // Physical address
    output reg         resp_abort_o,   // Reference aborted
    output reg         resp_trap_o,    // Trap noted
    input  wire        instr_done_i,   // Instruction end
    output reg         trap_req_o,     // Deferred trap
    input  wire        stat_load_i,      // Status load
    input  wire [15:0] stat_i,           // Status word
    input  wire        vec_stat_valid_i, // Vector status
    input  wire [15:0] vec_stat_i,       // Vector status word
    input  wire        priv_instr_i,   // Privileged instr
    output wire        priv_fault_o,   // Refused instr
    output wire [1:0]  cur_mode_o,     // Current mode
    output wire [1:0]  stack_mode_o,   // Push stack
    output wire        stack_push_o    // Push pulse
);
    localparam PW = $clog2(PAGES);
    localparam AW = PW + 2;

    reg  [1:0]  ctrl_q;
    reg         abt_q;
    reg         trp_q;
    reg  [18:0] fadr_q;
    reg         s1_valid_q;
    reg  [15:0] s1_vaddr_q;
    reg         s1_write_q;
    reg         s1_ok_q;
    reg  [1:0]  s1_mode_q;
    wire        mode_ok;
    wire [15:0] base_rd;
    wire [9:0]  desc_rd;
    wire [15:0] base_bd;
    wire [9:0]  desc_bd;
    wire        en = ctrl_q[`PARU_CTRL_EN];
    wire        w22 = ctrl_q[`PARU_CTRL_W22];

    // Bus decode
    wire        wb_req = wb_cyc_i && wb_stb_i;
    wire        is_map = !wb_adr_i[`PARU_MAP_SEL] &&
                         (wb_adr_i[11:9] == 3'h0);
    wire        is_desc = wb_adr_i[`PARU_MAP_DESC];
    wire [AW-1:0] wb_idx = wb_adr_i[AW+1:2];
    wire        wb_kern = (cur_mode_o == `PARU_MODE_KER);
    wire        wb_wr = wb_req && wb_we_i && wb_ack_o && wb_kern;
    wire        we_base = wb_wr && is_map && !is_desc;
    wire        we_desc = wb_wr && is_map && is_desc;
    wire        we_ctrl = wb_wr && (wb_adr_i == `PARU_OFF_CTRL);
    wire        we_stat = wb_wr && (wb_adr_i == `PARU_OFF_STAT);
    wire [9:0]  desc_wd = {wb_dat_i[`PARU_DESC_LEN_HI:`PARU_DESC_LEN_LO],
                           wb_dat_i[2:0]};

    wire [1:0]  sel_mode = (req_vector_i && en) ? `PARU_MODE_KER
                                                : cur_mode_o;
    wire [AW-1:0] tr_idx = {sel_mode, req_vaddr_i[15:16-PW]};
    wire        sel_ok = req_vector_i || mode_ok;

    paru_mode_ctl #(
        .SUP_EN (SUP_EN)
    ) u_mode (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .stat_load_i      (stat_load_i),
        .stat_i           (stat_i),
        .vec_stat_valid_i (vec_stat_valid_i),
        .vec_stat_i       (vec_stat_i),
        .priv_instr_i   (priv_instr_i),
        .cur_mode_o     (cur_mode_o),
        .stack_mode_o   (stack_mode_o),
        .stack_push_o   (stack_push_o),
        .priv_fault_o   (priv_fault_o),
        .mode_ok_o      (mode_ok)
    );

    paru_map_mem #(
        .WIDTH (16),
        .AW    (AW)
    ) u_base (
        .clk_i (clk_i),
        .we_i  (we_base),
        .be_i  (wb_sel_i[1:0]),
        .wa_i  (wb_idx),
        .wd_i  (wb_dat_i[15:0]),
        .ra_i  (tr_idx),
        .rd_o  (base_rd),
        .rb_i  (wb_idx),
        .rbd_o (base_bd)
    );

    paru_map_mem #(
        .WIDTH (10),
        .AW    (AW)
    ) u_desc (
        .clk_i (clk_i),
        .we_i  (we_desc),
        .be_i  (wb_sel_i[1:0]),
        .wa_i  (wb_idx),
        .wd_i  (desc_wd),
        .ra_i  (tr_idx),
        .rd_o  (desc_rd),
        .rb_i  (wb_idx),
        .rbd_o (desc_bd)
    );

    // Stage one capture
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_valid_q <= 1'b0;
            s1_vaddr_q <= 16'h0000;
            s1_write_q <= 1'b0;
            s1_ok_q    <= 1'b0;
            s1_mode_q  <= `PARU_MODE_KER;
        end else begin
            s1_valid_q <= req_valid_i;
            if (req_valid_i) begin
                s1_vaddr_q <= req_vaddr_i;
                s1_write_q <= req_write_i;
                s1_ok_q    <= sel_ok;
                s1_mode_q  <= sel_mode;
            end
        end
    end

    // Translation and checks
    wire [2:0]  key_code = desc_rd[2:0];
    wire [6:0]  plen = desc_rd[9:3];
    wire [6:0]  vblk = s1_vaddr_q[12:`PARU_BLK_BITS];
    // page of 1 to 128 blocks
    wire        len_bad = (vblk > plen);
    wire [21:0] sum = {base_rd, {`PARU_BLK_BITS{1'b0}}} +
                      {9'h000, s1_vaddr_q[12:0]};
    wire [21:0] io_pg = {6'h3f, s1_vaddr_q};
    reg         key_abt;
    reg         key_trp;

    always @* begin
        key_abt = 1'b1;
        key_trp = 1'b0;
        case (key_code)
            `PARU_KEY_RO_TRP: begin
                key_abt = s1_write_q;
                key_trp = !s1_write_q;
            end
            `PARU_KEY_RO: begin
                key_abt = s1_write_q;
            end
            `PARU_KEY_RW_TRP: begin
                key_abt = 1'b0;
                key_trp = 1'b1;
            end
            `PARU_KEY_RW: begin
                key_abt = 1'b0;
            end
            default: begin
                key_abt = 1'b1;
            end
        endcase
    end

    wire        abt_n = en && (!s1_ok_q || key_abt || len_bad);
    wire        trp_n = en && !abt_n && key_trp;
    reg  [21:0] pa_n;

    always @* begin
        if (!en) begin
            pa_n = (s1_vaddr_q[15:13] == 3'h7) ? io_pg
                                               : {6'h00, s1_vaddr_q};
        end else begin
            pa_n = sum;
        end
        if (!w22)
            pa_n[21:18] = 4'h0;
    end

    // Result registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            resp_valid_o <= 1'b0;
            resp_paddr_o <= 22'h000000;
            resp_abort_o <= 1'b0;
            resp_trap_o  <= 1'b0;
        end else begin
            resp_valid_o <= s1_valid_q;
            if (s1_valid_q) begin
                resp_paddr_o <= pa_n;
                resp_abort_o <= abt_n;
                resp_trap_o  <= trp_n;
            end else begin
                resp_abort_o <= 1'b0;
                resp_trap_o  <= 1'b0;
            end
        end
    end

    // Deferred trap and fault status
    always @(posedge clk_i) begin
        if (rst_i) begin
            trp_q      <= 1'b0;
            trap_req_o <= 1'b0;
            abt_q      <= 1'b0;
            fadr_q     <= 19'h00000;
        end else begin
            trap_req_o <= instr_done_i && trp_q;
            if (resp_valid_o && resp_trap_o)
                trp_q <= 1'b1;
            else if (instr_done_i)
                trp_q <= 1'b0;
            if (resp_valid_o && resp_abort_o)
                abt_q <= 1'b1;
            else if (we_stat && wb_sel_i[0] && wb_dat_i[`PARU_STAT_ABT])
                abt_q <= 1'b0;
            if (s1_valid_q && abt_n)
                fadr_q <= {s1_mode_q, s1_write_q, s1_vaddr_q};
        end
    end

    // Control register and bus answer
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q   <= `PARU_CTRL_RST;
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
            if (we_ctrl && wb_sel_i[0])
                ctrl_q <= wb_dat_i[1:0];
        end
    end

    always @* begin
        wb_dat_o = 32'h00000000;
        if (wb_ack_o && !wb_we_i) begin
            if (is_map && !is_desc)
                wb_dat_o = {16'h0000, base_bd};
            else if (is_map)
                wb_dat_o = {17'h00000, desc_bd[9:3], 5'h00, desc_bd[2:0]};
            else if (wb_adr_i == `PARU_OFF_CTRL)
                wb_dat_o = {30'h00000000, ctrl_q};
            else if (wb_adr_i == `PARU_OFF_STAT)
                wb_dat_o = {26'h0000000, cur_mode_o, 2'h0, trp_q, abt_q};
            else if (wb_adr_i == `PARU_OFF_FADR)
                wb_dat_o = {13'h0000, fadr_q};
        end
    end
endmodule // paru_top
`default_nettype wire

// ### paru_monitor.sv
/*
 Port checker of the relocation unit.
 Assumes binding to paru_top; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module paru_monitor #(
    parameter SUP_EN = 1,
    parameter PAGES  = 8
) (
    input wire logic        clk_i,          // Clock
    input wire logic        rst_i,          // Reset
    input wire logic        wb_cyc_i,       // Cycle
    input wire logic        wb_stb_i,       // Strobe
    input wire logic        wb_ack_o,       // Ack
    input wire logic        req_valid_i,    // Reference
    input wire logic [15:0] req_vaddr_i,    // Vaddr
    input wire logic        resp_valid_o,   // Result
    input wire logic [21:0] resp_paddr_o,   // Paddr
    input wire logic        resp_abort_o,   // Abort
    input wire logic        resp_trap_o,    // Trap
    input wire logic        instr_done_i,   // Instr end
    input wire logic        trap_req_o,     // Deferred trap
    input wire logic        stat_load_i,      // Status load
    input wire logic [15:0] stat_i,           // Status
    input wire logic        vec_stat_valid_i, // Vector status
    input wire logic [15:0] vec_stat_i,       // Vector word
    input wire logic        priv_instr_i,   // Privileged
    input wire logic        priv_fault_o,   // Refused
    input wire logic [1:0]  cur_mode_o,     // Mode
    input wire logic [1:0]  stack_mode_o,   // Stack
    input wire logic        stack_push_o    // Push
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_vec;
        vec_stat_valid_i;
    endsequence
    sequence s_new_mode;
        stack_push_o && stack_mode_o == $past(vec_stat_i[15:14]) && cur_mode_o == stack_mode_o;
    endsequence
    property p_lat; req_valid_i |-> ##2 resp_valid_o; endproperty
    a_lat: assert property (p_lat) else $error("result late");
    property p_nospur; resp_valid_o |-> $past(req_valid_i, 2); endproperty
    a_nospur: assert property (p_nospur) else $error("result without request");
    property p_off; resp_valid_o |-> resp_paddr_o[5:0] == $past(req_vaddr_i[5:0], 2); endproperty
    a_off: assert property (p_off) else $error("block offset changed");
    property p_flag; (resp_abort_o || resp_trap_o) |-> resp_valid_o; endproperty
    a_flag: assert property (p_flag) else $error("flag without result");
    property p_priv; priv_instr_i && cur_mode_o != 2'h0 |=> priv_fault_o; endproperty
    a_priv: assert property (p_priv) else $error("privileged not refused");
    property p_ker; priv_instr_i && cur_mode_o == 2'h0 |=> !priv_fault_o; endproperty
    a_ker: assert property (p_ker) else $error("kernel refused");
    property p_stat; stat_load_i && !vec_stat_valid_i |=> cur_mode_o == $past(stat_i[15:14]); endproperty
    a_stat: assert property (p_stat) else $error("mode not loaded");
    property p_vec; s_vec |=> s_new_mode; endproperty
    a_vec: assert property (p_vec) else $error("vector push wrong");
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack1: assert property (p_ack1) else $error("ack too long");
    property p_trap; trap_req_o |-> $past(instr_done_i); endproperty
    a_trap: assert property (p_trap) else $error("trap before instruction end");
endmodule // paru_monitor
bind paru_top paru_monitor #(.SUP_EN(SUP_EN), .PAGES(PAGES)) mon_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .req_valid_i(req_valid_i), .req_vaddr_i(req_vaddr_i), .resp_valid_o(resp_valid_o),
    .resp_paddr_o(resp_paddr_o), .resp_abort_o(resp_abort_o), .resp_trap_o(resp_trap_o),
    .instr_done_i(instr_done_i), .trap_req_o(trap_req_o), .stat_load_i(stat_load_i), .stat_i(stat_i),
    .vec_stat_valid_i(vec_stat_valid_i), .vec_stat_i(vec_stat_i), .priv_instr_i(priv_instr_i),
    .priv_fault_o(priv_fault_o), .cur_mode_o(cur_mode_o), .stack_mode_o(stack_mode_o),
    .stack_push_o(stack_push_o));
`default_nettype wire

// ### paru_core_model.sv
/*
 Core model issuing one-cycle virtual references.
 Assumes the unit samples the reference at the next rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module paru_core_model (
    input  wire logic  clk_i,        // Clock
    output logic        req_valid_o,  // Reference strobe
    output logic [15:0] req_vaddr_o,  // Virtual address
    output logic        req_write_o,  // Write reference
    output logic        req_vector_o  // Vector fetch
);
    initial begin
        req_valid_o = 1'b0;
        req_vaddr_o = 16'h0000;
        req_write_o = 1'b0;
        req_vector_o = 1'b0;
    end
    task automatic issue(input logic [15:0] v, input logic w, input logic vec);
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_vaddr_o <= v;
        req_write_o <= w;
        req_vector_o <= vec;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        // Released lines carry no stale value
        req_vaddr_o <= ~v;
        req_write_o <= ~w;
        req_vector_o <= ~vec;
    endtask
endmodule // paru_core_model
`default_nettype wire

// ### tb_top.sv
/*
 Self-checking bench of the relocation unit.
 Assumes paru_top, the core model and the checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, seed = 32'h8c3e, rd;
    logic        instr_done_i = 1'b0, stat_load_i = 1'b0, vec_stat_valid_i = 1'b0, priv_instr_i = 1'b0;
    logic [15:0] stat_i = 16'h0, vec_stat_i = 16'h0, va;
    logic [15:0] base [8];
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, req_valid_i, req_write_i, req_vector_i, resp_valid_o, resp_abort_o;
    wire         resp_trap_o, trap_req_o, priv_fault_o, stack_push_o;
    wire  [15:0] req_vaddr_i;
    wire  [21:0] resp_paddr_o;
    wire  [1:0]  cur_mode_o, stack_mode_o;
    int          error_cnt = 0, tests_run = 0;
    paru_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i), .req_vaddr_i(req_vaddr_i),
        .req_write_i(req_write_i), .req_vector_i(req_vector_i), .resp_valid_o(resp_valid_o),
        .resp_paddr_o(resp_paddr_o), .resp_abort_o(resp_abort_o), .resp_trap_o(resp_trap_o),
        .instr_done_i(instr_done_i), .trap_req_o(trap_req_o), .stat_load_i(stat_load_i), .stat_i(stat_i),
        .vec_stat_valid_i(vec_stat_valid_i), .vec_stat_i(vec_stat_i), .priv_instr_i(priv_instr_i),
        .priv_fault_o(priv_fault_o), .cur_mode_o(cur_mode_o), .stack_mode_o(stack_mode_o),
        .stack_push_o(stack_push_o));
    paru_core_model core_u (.clk_i(clk_i), .req_valid_o(req_valid_i), .req_vaddr_o(req_vaddr_i),
        .req_write_o(req_write_i), .req_vector_o(req_vector_i));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [21:0] epa(input logic [15:0] b, input logic [15:0] v, input logic w22);
        logic [21:0] s;
        s = {b, 6'h00} + {9'h000, v[12:0]};
        return w22 ? s : {4'h0, s[17:0]};
    endfunction
    // Expected {abort, trap} of a key
    function automatic logic [1:0] key_exp(input logic [2:0] k, input logic w);
        case (k)
            3'h1: key_exp = w ? 2'h2 : 2'h1;
            3'h2: key_exp = w ? 2'h2 : 2'h0;
            3'h4: key_exp = 2'h1;
            3'h5: key_exp = 2'h0;
            default: key_exp = 2'h2;
        endcase
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'h3;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic mapw(input logic [1:0] m, input logic [2:0] p, input logic [15:0] b,
                        input logic [6:0] n, input logic [2:0] k);
        wb(1'b1, {5'h00, m, p, 2'h0}, {16'h0, b}, rd);
        wb(1'b1, {5'h01, m, p, 2'h0}, {17'h0, n, 5'h00, k}, rd);
    endtask
    task automatic xl(input logic [15:0] v, input logic w, input logic vec, input logic [21:0] e,
                      input logic [1:0] f);
        core_u.issue(v, w, vec);
        @(posedge clk_i);
        #1;
        chk({31'h0, resp_valid_o}, 32'h1);
        chk({10'h0, resp_paddr_o}, {10'h0, e});
        chk({30'h0, resp_abort_o, resp_trap_o}, {30'h0, f});
    endtask
    task automatic pulse(input int s, input logic [15:0] w);
        @(posedge clk_i);
        stat_i <= w;
        vec_stat_i <= w;
        stat_load_i <= (s == 0);
        vec_stat_valid_i <= (s == 1);
        priv_instr_i <= (s == 2);
        instr_done_i <= (s == 3);
        @(posedge clk_i);
        stat_load_i <= 1'b0;
        vec_stat_valid_i <= 1'b0;
        priv_instr_i <= 1'b0;
        instr_done_i <= 1'b0;
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 12'h100, 32'h0, rd);
        chk(rd, 32'h0);
        chk({30'h0, cur_mode_o}, 32'h0);
        xl(16'h2345, 1'b0, 1'b0, 22'h002345, 2'h0);
        xl(16'he010, 1'b1, 1'b0, 22'h03e010, 2'h0);
        $display("test pass-through done");
        for (int p = 0; p < 8; p++) begin
            seed = lfsr(seed);
            base[p] = seed[15:0];
            mapw(2'h0, p[2:0], base[p], 7'h7f, 3'h5);
        end
        wb(1'b0, 12'h004, 32'h0, rd);
        chk(rd, {16'h0, base[1]});
        wb(1'b1, 12'h100, 32'h1, rd);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            va = seed[15:0];
            if (i == 16) wb(1'b1, 12'h100, 32'h3, rd);
            xl(va, seed[16], 1'b0, epa(base[va[15:13]], va, i >= 16), 2'h0);
        end
        mapw(2'h0, 3'h6, base[4], 7'h7f, 3'h2);
        xl(16'h8abc, 1'b1, 1'b0, epa(base[4], 16'h8abc, 1'b1), 2'h0);
        xl(16'hcabc, 1'b1, 1'b0, epa(base[4], 16'hcabc, 1'b1), 2'h2);
        mapw(2'h0, 3'h1, base[1], 7'h03, 3'h5);
        xl(16'h20ff, 1'b0, 1'b0, epa(base[1], 16'h20ff, 1'b1), 2'h0);
        xl(16'h2100, 1'b0, 1'b0, epa(base[1], 16'h2100, 1'b1), 2'h2);
        wb(1'b0, 12'h084, 32'h0, rd);
        chk(rd, 32'h305);
        wb(1'b0, 12'h108, 32'h0, rd);
        chk(rd, 32'h2100);
        wb(1'b0, 12'h104, 32'h0, rd);
        chk(rd, 32'h1);
        wb(1'b1, 12'h104, 32'h1, rd);
        wb(1'b0, 12'h104, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test relocation done");
        for (int k = 0; k < 16; k++) begin
            mapw(2'h0, 3'h2, base[2], 7'h7f, k[3:1]);
            xl(16'h4040, k[0], 1'b0, epa(base[2], 16'h4040, 1'b1), key_exp(k[3:1], k[0]));
        end
        mapw(2'h0, 3'h2, base[2], 7'h7f, 3'h4);
        xl(16'h4080, 1'b0, 1'b0, epa(base[2], 16'h4080, 1'b1), 2'h1);
        pulse(3, 16'h0);
        chk({31'h0, trap_req_o}, 32'h1);
        $display("test access keys done");
        seed = lfsr(seed);
        mapw(2'h1, 3'h0, seed[15:0], 7'h7f, 3'h5);
        mapw(2'h3, 3'h0, seed[31:16], 7'h7f, 3'h5);
        pulse(0, 16'h4000);
        chk({30'h0, cur_mode_o}, 32'h1);
        xl(16'h0123, 1'b0, 1'b0, epa(seed[15:0], 16'h0123, 1'b1), 2'h0);
        xl(16'h0123, 1'b0, 1'b1, epa(base[0], 16'h0123, 1'b1), 2'h0);
        pulse(2, 16'h0);
        chk({31'h0, priv_fault_o}, 32'h1);
        wb(1'b1, 12'h100, 32'h0, rd);
        wb(1'b0, 12'h100, 32'h0, rd);
        chk(rd, 32'h3);
        pulse(1, 16'hc000);
        chk({27'h0, stack_push_o, stack_mode_o, cur_mode_o}, 32'h1f);
        xl(16'h0040, 1'b1, 1'b0, epa(seed[31:16], 16'h0040, 1'b1), 2'h0);
        pulse(2, 16'h0);
        chk({31'h0, priv_fault_o}, 32'h1);
        pulse(1, 16'h0000);
        chk({27'h0, stack_push_o, stack_mode_o, cur_mode_o}, 32'h10);
        mapw(2'h2, 3'h0, base[0], 7'h7f, 3'h5);
        pulse(0, 16'h8000);
        xl(16'h0123, 1'b0, 1'b0, epa(base[0], 16'h0123, 1'b1), 2'h2);
        pulse(0, 16'h0000);
        pulse(2, 16'h0);
        chk({31'h0, priv_fault_o}, 32'h0);
        wb(1'b0, 12'h200, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test modes done");
        summarize();
    end
endmodule // tb_top
`default_nettype wire
